// [hw/pplt_edge.sv]
// pplt_edge: two-flop synchroniser with edge detection per bit
// assumes asynchronous pins; the second and third flops feed the edges
`timescale 1ns/1ps
module pplt_edge
	import pplt_pkg::*;
#(
	parameter int W = 1
)(
	input  wire logic         pclk,    // system clock
	input  wire logic         presetn, // async reset, active low
	input  wire logic [W-1:0] pin,     // raw pins
	output logic      [W-1:0] lvl,     // synchronised level
	output logic      [W-1:0] rise,    // one-cycle rising pulse
	output logic      [W-1:0] fall     // one-cycle falling pulse
);
	typedef struct packed
	{
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] prv;
	} pplt_edge_type;
	pplt_edge_type s_q;
	pplt_edge_type s_d;

	// shift the pins through the chain
	always_comb
	begin
		s_d     = s_q;
		s_d.s1  = pin;
		s_d.s2  = s_q.s1;
		s_d.prv = s_q.s2;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	// edges look only at the second and third flops
	assign lvl  = s_q.s2;
	assign rise = s_q.s2 & ~s_q.prv;
	assign fall = ~s_q.s2 & s_q.prv;
endmodule

// [hw/pplt_pkg.sv]
// pplt_pkg: constants shared by the loop transceiver pin logic
// assumes a 40 MHz pclk and a 32-bit apb register bus
package pplt_pkg;
	// clock and derived timing
	localparam int CLK_HZ    = 40_000_000;
	localparam int BCLK_HZ   = 128_000;
	localparam int BCLK_HALF = CLK_HZ / (2 * BCLK_HZ);
	localparam int TONE_HZ   = 500;
	localparam int TONE_HALF = CLK_HZ / (2 * TONE_HZ);
	localparam int PWR_US    = 250;
	localparam int PWR_CYC   = PWR_US * (CLK_HZ / 1_000_000);
	// sequence figures
	localparam int BCLK_PER  = 16;
	localparam int B_BITS    = 8;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STAT = 8'h04;
	localparam logic [7:0] ADDR_RXB  = 8'h08;
	localparam logic       CTRL_AUTO_RST = 1'b1;
	// pcm words that make the square-wave tone
	localparam logic [7:0] TONE_HI = 8'h2A;
	localparam logic [7:0] TONE_LO = 8'hAA;
	// positions of the sampled pins in the sync vector
	localparam int P_ROLE = 0;
	localparam int P_WIDE = 1;
	localparam int P_PD   = 2;
	localparam int P_LWS  = 3;
	localparam int P_SIE  = 4;
	localparam int P_TONE = 5;
	localparam int P_FS   = 6;
	localparam int P_BDC  = 7;
	localparam int P_TE1  = 8;
	localparam int P_TE2  = 9;
	localparam int P_BIN  = 10;
	localparam int P_DCK  = 11;
	localparam int P_DI1  = 12;
	localparam int P_DI2  = 13;
	localparam int P_NUM  = 14;
	// slave clock burst sequencer, gray along idle-high-low
	typedef enum logic [1:0]
	{
		SQ_IDLE = 2'b00,
		SQ_HIGH = 2'b01,
		SQ_LOW  = 2'b11
	} pplt_sq_type;
endpackage

// [hw/pplt_tick.sv]
// pplt_tick: enable pulse generator, one pulse every n cycles
// assumes a single pclk domain; clr restarts the period
`timescale 1ns/1ps
module pplt_tick
	import pplt_pkg::*;
#(
	parameter int N = BCLK_HALF
)(
	input  wire logic pclk,    // system clock
	input  wire logic presetn, // async reset, active low
	input  wire logic clr,     // restart the period
	output logic      tick     // one-cycle pulse
);
	localparam int W = $clog2(N + 1);
	typedef struct packed
	{
		logic [W-1:0] cnt;
		logic         tick;
	} pplt_tick_type;
	pplt_tick_type s_q;
	pplt_tick_type s_d;

	// count up and wrap, pulsing at the wrap
	always_comb
	begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (clr)
			s_d.cnt = '0;
		else if (s_q.cnt == W'(N - 1))
		begin
			s_d.cnt  = '0;
			s_d.tick = 1'b1;
		end
		else
			s_d.cnt = s_q.cnt + 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;
endmodule

// [hw/pplt_top.sv]
// pplt_top: digital pin logic of a ping-pong burst loop transceiver
// assumes a demodulator and modulator on pclk beside it; all pins
// from the codec side are asynchronous and are synchronised here
//
// Overview of operation
// [RULE_01] master wideband: clock pin times both D channels
// [RULE_02] master narrowband: D clock pin undriven
// [RULE_03] slave wideband: D clock starts, aligned to windows
// [RULE_04] slave wideband: two D clocks, then low
// [RULE_05] slave narrowband: D clock equals b1 window
// [RULE_06] master wideband: two D bits per frame
// [RULE_07] frame sync shows first bit; advance on fall
// [RULE_08] slave auto power-down after 250 us silence
// [RULE_09] power pin low: only demodulator runs
// [RULE_10] waveform select picks triangle or square line
// [RULE_11] master narrowband: B out under b1 enable
// [RULE_12] slave narrowband: B out on clock rises
// [RULE_13] master wideband: B out under both enables
// [RULE_14] slave wideband: eight B1 then eight B2
// [RULE_15] signal insert puts slave bit in LSB
// [RULE_16] frame sync loads modulator, launches burst
// [RULE_17] frame sync buffers last frame's received data
// [RULE_18] frame sync roughly aligned with data clock
// [RULE_19] slave tone replaces received PCM with 500 Hz
// [RULE_20] master narrowband convert clock 2.048 MHz
// [RULE_21] master wideband convert clock 8.192 MHz
// [RULE_22] slave narrowband timebase 4.096 MHz crystal
// [RULE_23] one burst per frame, 10 or 20 bits
// [RULE_24] slave B clock: 16 periods of 128 kHz
// [RULE_25] role and width pins select pin behaviour
//
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module pplt_top
	import pplt_pkg::*;
#(
	parameter int PWR_CYCLES = PWR_CYC,  // silence before power-down
	parameter int TONE_CYC   = TONE_HALF // half period of the tone
)(
	input  wire logic        pclk,                  // 40 MHz clock
	input  wire logic        presetn,               // async reset
	input  wire logic        psel,                  // apb select
	input  wire logic        penable,               // apb enable
	input  wire logic        pwrite,                // apb write
	input  wire logic [7:0]  paddr,                 // apb address
	input  wire logic [31:0] pwdata,                // apb write data
	output logic      [31:0] prdata,                // apb read data
	output logic             pready,                // apb ready
	output logic             pslverr,               // apb error
	input  wire logic        role_select,           // high: master
	input  wire logic        burst_length_select,   // high: wideband
	input  wire logic        power_down_pin,        // low: power down
	input  wire logic        line_waveform_select,  // high: square
	input  wire logic        signal_insert_enable,  // lsb insert
	input  wire logic        tone_insert,           // slave tone
	input  wire logic        frame_sync_in,         // 8 kHz frame sync
	input  wire logic        b_data_clock,          // master B clock
	input  wire logic        b1_transmit_enable,    // B1 enable
	input  wire logic        b2_transmit_enable,    // B2 enable
	input  wire logic        b_data_in,             // B serial in
	output logic             b_data_out,            // B serial out
	output logic             b_data_out_oe,         // B out drive
	input  wire logic        d_channel_clock_i,     // D clock pin in
	output logic             d_channel_clock_o,     // D clock pin out
	output logic             d_channel_clock_oe,    // D clock drive
	input  wire logic        d_channel_in_1,        // D1 serial in
	input  wire logic        d_channel_in_2,        // D2 serial in
	output logic             d_channel_out_1,       // D1 serial out
	output logic             d_channel_out_2,       // D2 serial out
	output logic             b1_window_out,         // slave B1 window
	output logic             b2_window_out,         // slave B2 window
	output logic             b_channel_clock_out,   // slave B clock
	input  wire logic        demod_ok,              // burst received
	input  wire logic [7:0]  demod_b1,              // received B1
	input  wire logic [7:0]  demod_b2,              // received B2
	input  wire logic [1:0]  demod_d1,              // received D1
	input  wire logic [1:0]  demod_d2,              // received D2
	output logic             mod_launch,            // start a burst
	output logic      [15:0] mod_b,                 // B1,B2 to send
	output logic      [3:0]  mod_d,                 // D1,D2 to send
	output logic             mod_power_on,          // transmit powered
	output logic             mod_square,            // square waveform
	output logic             mod_burst_20           // 20-bit bursts
);
	localparam int IW = $clog2(PWR_CYCLES + 1);

	typedef struct packed
	{
		logic          auto_pw;
		logic          pready;
		logic          pslverr;
		logic [31:0]   prdata;
		logic          role;
		logic          wide;
		logic          pwr;
		logic          square;
		logic [IW-1:0] idle;
		logic [7:0]    gb1;
		logic [7:0]    gb2;
		logic [7:0]    mb1;
		logic [7:0]    mb2;
		logic [1:0]    gd1;
		logic [1:0]    gd2;
		logic [1:0]    md1;
		logic [1:0]    md2;
		logic [2:0]    bidx;
		logic          dsel;
		logic [15:0]   mod_b;
		logic [3:0]    mod_d;
		logic          launch;
		pplt_sq_type   sq;
		logic [3:0]    cnt;
		logic [15:0]   sh;
		logic          tone_ph;
		logic          bout;
		logic          boe;
		logic          dclk_o;
		logic          dclk_oe;
		logic          dout1;
		logic          dout2;
		logic          w1;
		logic          w2;
		logic          bclk;
	} pplt_state_type;

	pplt_state_type      s;
	pplt_state_type      n;
	logic [P_NUM-1:0]    raw;
	logic [P_NUM-1:0]    lv;
	logic [P_NUM-1:0]    rs;
	logic [P_NUM-1:0]    fl;
	logic                btick;
	logic                ttick;
	logic                bclr;
	logic                act;
	logic                selb2;
	logic                ben;
	logic [7:0]          word;
	logic [7:0]          tword;

	// every asynchronous pin passes the same two-flop chain
	assign raw = {d_channel_in_2, d_channel_in_1, d_channel_clock_i,
		b_data_in, b2_transmit_enable, b1_transmit_enable,
		b_data_clock, frame_sync_in, tone_insert, signal_insert_enable,
		line_waveform_select, power_down_pin, burst_length_select,
		role_select};

	pplt_edge #(.W(P_NUM)) u_sync
	(
		.pclk    (pclk),
		.presetn (presetn),
		.pin     (raw),
		.lvl     (lv),
		.rise    (rs),
		.fall    (fl)
	);

	// restarting the half-period on a burst keeps the slave locked
	assign bclr = demod_ok & ~s.role;

	pplt_tick #(.N(BCLK_HALF)) u_btick
	(
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (bclr),
		.tick    (btick)
	);

	pplt_tick #(.N(TONE_CYC)) u_ttick
	(
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (1'b0),
		.tick    (ttick)
	);

	// next-state logic for bus, power, master and slave paths
	always_comb
	begin
		n        = s;
		n.launch = 1'b0;
		n.role   = lv[P_ROLE];    // [RULE_25]
		n.wide   = lv[P_WIDE];    // [RULE_25]
		n.square = lv[P_LWS];     // [RULE_10]
		act      = 1'b0;
		selb2    = 1'b0;
		ben      = 1'b0;
		word     = 8'h00;
		tword    = s.tone_ph ? TONE_HI : TONE_LO;

		// apb: answer in the first access cycle, no wait states
		n.pready  = psel & ~penable;
		n.pslverr = 1'b0;
		n.prdata  = 32'h0000_0000;
		if (psel && !penable)
		begin
			case (paddr)
				ADDR_CTRL: n.prdata[0] = s.auto_pw;
				ADDR_STAT: n.prdata[4:0] = {s.sq != SQ_IDLE, s.pwr,
					s.square, s.wide, s.role};
				ADDR_RXB:  n.prdata[19:0] = {s.md2, s.md1, s.mb2, s.mb1};
				default:   n.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && s.pready && pwrite && paddr == ADDR_CTRL)
			n.auto_pw = pwdata[0];

		// power: a burst clears the silence count, the pin overrides
		if (demod_ok)
			n.idle = '0;
		else if (s.idle != IW'(PWR_CYCLES))
			n.idle = s.idle + 1'b1;
		n.pwr = lv[P_PD] & ~(~s.role & s.auto_pw &
			(s.idle == IW'(PWR_CYCLES)));    // [RULE_08] [RULE_09]
		if (ttick)
			n.tone_ph = ~s.tone_ph;

		if (s.role)
		begin
			// master: frame sync swaps the frame buffers
			n.dclk_oe = 1'b0;    // [RULE_02]
			n.w1      = 1'b0;
			n.w2      = 1'b0;
			n.bclk    = 1'b0;
			n.sq      = SQ_IDLE;
			if (rs[P_FS])
			begin
				n.mod_b  = {s.gb1, s.gb2};    // [RULE_16]
				n.mod_d  = {s.gd1, s.gd2};
				n.launch = s.pwr;    // [RULE_16] [RULE_23]
				n.mb1    = demod_b1;    // [RULE_17]
				n.mb2    = demod_b2;
				n.md1    = demod_d1;
				n.md2    = demod_d2;
				n.dsel   = 1'b0;
				n.dout1  = s.wide ? demod_d1[1] : demod_d1[0];    // [RULE_07]
				n.dout2  = s.wide ? demod_d2[1] : demod_d2[0];
				if (!s.wide)
				begin
					// narrowband signalling: one bit per frame
					n.gd1 = {s.gd1[0], lv[P_DI1]};
					if (!lv[P_SIE])
						n.gd2 = {s.gd2[0], lv[P_DI2]};    // [RULE_15]
				end
			end
			else if (s.wide && fl[P_DCK] && !s.dsel)
			begin
				// second bit of each D channel on the clock fall
				n.dsel  = 1'b1;    // [RULE_06] [RULE_07]
				n.dout1 = s.md1[0];
				n.dout2 = s.md2[0];
			end
			if (s.wide && rs[P_DCK])
			begin
				n.gd1 = {s.gd1[0], lv[P_DI1]};    // [RULE_01]
				n.gd2 = {s.gd2[0], lv[P_DI2]};
			end

			// B path: b2 wins only when b1 is low; both high selects b1
			selb2 = s.wide & lv[P_TE2] & ~lv[P_TE1];
			ben   = lv[P_TE1] | (s.wide & lv[P_TE2]);
			word  = selb2 ? s.mb2 : s.mb1;
			n.boe = ben;    // [RULE_11] [RULE_13]
			if (rs[P_TE1] || (s.wide && rs[P_TE2]))
				n.bidx = 3'd0;
			else if (ben && rs[P_BDC])
			begin
				n.bout = word[3'd7 - s.bidx];    // [RULE_11] [RULE_13]
				if (!s.wide && lv[P_SIE] && s.bidx == 3'd7)
					n.bout = s.md2[0];    // [RULE_15]
				n.bidx = s.bidx + 1'b1;
			end
			if (ben && fl[P_BDC])
			begin
				if (selb2)
					n.gb2 = {s.gb2[6:0], lv[P_BIN]};
				else
					n.gb1 = {s.gb1[6:0], lv[P_BIN]};
			end
		end
		else
		begin
			// slave: each received burst starts 16 clock periods
			n.dclk_oe = 1'b1;
			if (demod_ok)
			begin
				n.sq  = SQ_HIGH;    // [RULE_24]
				n.cnt = 4'd0;
				n.sh  = lv[P_TONE] ? {tword, tword}
					: {demod_b1, demod_b2};    // [RULE_19]
				n.gd1 = {s.gd1[0], lv[P_DI1]};
				n.gd2 = {s.gd2[0], lv[P_DI2]};
			end
			else if (btick)
			begin
				case (s.sq)
					SQ_HIGH:
					begin
						n.sq = SQ_LOW;
						if (s.w1)
							n.gb1 = {s.gb1[6:0], lv[P_BIN]};
						else if (s.w2)
							n.gb2 = {s.gb2[6:0], lv[P_BIN]};
					end
					SQ_LOW:
					begin
						if (s.cnt == 4'(BCLK_PER - 1))
						begin
							// pong goes out once the frame's clocks end
							n.sq     = SQ_IDLE;    // [RULE_24]
							n.mod_b  = {s.gb1, s.gb2};
							n.mod_d  = {s.gd1, s.gd2};
							n.launch = s.pwr;    // [RULE_09]
						end
						else
						begin
							n.sq  = SQ_HIGH;
							n.cnt = s.cnt + 1'b1;
						end
					end
					SQ_IDLE: n.sq = SQ_IDLE;
					default: n.sq = SQ_IDLE;
				endcase
			end
			act    = n.sq != SQ_IDLE;
			n.bclk = n.sq == SQ_HIGH;    // [RULE_24]
			n.w1   = act & ~n.cnt[3];    // [RULE_14]
			n.w2   = act & s.wide & n.cnt[3];    // [RULE_14]
			// wideband: two D clocks of eight B periods each, then low
			n.dclk_o = s.wide ? (act & ~n.cnt[2])
				: n.w1;    // [RULE_03] [RULE_04] [RULE_05]
			n.boe  = n.w1 | n.w2;    // [RULE_12]
			if (n.sq == SQ_HIGH && s.sq != SQ_HIGH)
				n.bout = n.sh[4'd15 - n.cnt];    // [RULE_12] [RULE_14]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s         <= '0;
			s.auto_pw <= CTRL_AUTO_RST;
		end
		else
			s <= n;
	end

	// every output straight from the state register
	assign prdata              = s.prdata;
	assign pready              = s.pready;
	assign pslverr             = s.pslverr;
	assign b_data_out          = s.bout;
	assign b_data_out_oe       = s.boe;
	assign d_channel_clock_o   = s.dclk_o;
	assign d_channel_clock_oe  = s.dclk_oe;
	assign d_channel_out_1     = s.dout1;
	assign d_channel_out_2     = s.dout2;
	assign b1_window_out       = s.w1;
	assign b2_window_out       = s.w2;
	assign b_channel_clock_out = s.bclk;
	assign mod_launch          = s.launch;
	assign mod_b               = s.mod_b;
	assign mod_d               = s.mod_d;
	assign mod_power_on        = s.pwr;
	assign mod_square          = s.square;
	assign mod_burst_20        = s.wide;

	// checks on the pin behaviour
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	dclk_hiz_a: assert property ( // [RULE_02]
		s.role && $past(s.role) |-> !d_channel_clock_oe)
		else $error("master drives the D clock pin");
	wb_align_a: assert property ( // [RULE_03]
		!s.role && s.wide && $rose(d_channel_clock_o)
		|-> $rose(b_channel_clock_out) && (b1_window_out || b2_window_out))
		else $error("slave D clock rise not aligned");
	dclk_idle_a: assert property ( // [RULE_04]
		!s.role && s.sq == SQ_IDLE |-> !d_channel_clock_o)
		else $error("slave D clock high outside a frame");
	nb_dclk_a: assert property ( // [RULE_05]
		!s.role && !s.wide && $stable(s.wide)
		|-> d_channel_clock_o == b1_window_out)
		else $error("narrow slave D clock differs from window");
	win_excl_a: assert property ( // [RULE_14]
		!(b1_window_out && b2_window_out))
		else $error("both B windows high");
	sl_tri_a: assert property ( // [RULE_12]
		!s.role && !b1_window_out && !b2_window_out |-> !b_data_out_oe)
		else $error("slave B out driven outside windows");
	mw_tri_a: assert property ( // [RULE_13]
		s.role && $past(s.role) && s.wide && !lv[P_TE1] && !lv[P_TE2]
		|=> !b_data_out_oe)
		else $error("master B out driven with enables low");
	fs_load_a: assert property ( // [RULE_16]
		s.role && rs[P_FS] && s.pwr |=> mod_launch && mod_b == $past(
		{s.gb1, s.gb2}))
		else $error("frame sync did not launch the burst");
	pd_off_a: assert property ( // [RULE_09]
		!lv[P_PD] |=> !mod_power_on)
		else $error("powered while power pin low");
	tmo_off_a: assert property ( // [RULE_08]
		!s.role && s.auto_pw && s.idle == IW'(PWR_CYCLES) && !demod_ok
		|=> !mod_power_on)
		else $error("slave stayed up after silence");
	bclk_hold_a: assert property ( // [RULE_24]
		$rose(b_channel_clock_out) |=> b_channel_clock_out [*8])
		else $error("B clock high phase too short");

	slave_frame_c: cover property (
		s.sq == SQ_LOW && s.cnt == 4'(BCLK_PER - 1) && btick);
	master_frame_c: cover property (s.role && mod_launch);
	timeout_c: cover property (!s.role && $fell(mod_power_on));
endmodule

// [tb/pplt_far.sv]
// pplt_far: backplane side of a master line card
// assumes the bench calls its tasks; its clocks ignore pclk phase
`timescale 1ns/1ps
module pplt_far (
	output logic b_data_clock,  // free running data clock
	output logic frame_sync_in, // frame reference
	output logic d_clock        // D channel clock, idles high
);
	// data clock runs free at 200 ns, offset so edges never meet pclk
	initial
	begin
		b_data_clock = 0;
		frame_sync_in = 0;
		d_clock = 1;
		#37;
		forever #100 b_data_clock = ~b_data_clock;
	end
	// frame sync leads on a data clock rise
	task frame;
		@(posedge b_data_clock);
		frame_sync_in <= 1;
		repeat (8) @(posedge b_data_clock);
		frame_sync_in <= 0;
	endtask
	// one D clock period; its fall asks for the next bit
	task d_beat;
		@(posedge b_data_clock);
		d_clock <= 0;
		repeat (4) @(posedge b_data_clock);
		d_clock <= 1;
	endtask
endmodule

// [tb/tb_ping_pong_loop_transceiver_io.sv]
// tb_ping_pong_loop_transceiver_io: self-checking bench of the pin logic
// assumes pplt_top with a short power-down count and pplt_far beside it
`timescale 1ns/1ps
module tb_ping_pong_loop_transceiver_io;
	import pplt_pkg::*;
	localparam int PWR = 200;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, seed = 6;
	logic pready, pslverr, er, b_data_out, b_data_out_oe;
	logic role_select = 0, burst_length_select = 1, power_down_pin = 1;
	logic line_waveform_select = 0, b1_transmit_enable = 0, b_data_in = 0;
	logic tone = 0;
	logic d_channel_in_1 = 0, d_channel_in_2 = 0, demod_ok = 0;
	logic [7:0] demod_b1 = 0, demod_b2 = 0;
	logic [1:0] demod_d1 = 0, demod_d2 = 0;
	logic frame_sync_in, b_data_clock, d_clock, d_channel_clock_o;
	logic d_channel_clock_oe, d_channel_out_1, d_channel_out_2;
	logic b1_window_out, b2_window_out, b_channel_clock_out, mod_launch;
	logic [15:0] mod_b;
	logic [3:0] mod_d;
	logic mod_power_on, mod_square, mod_burst_20, bck_q = 0, dck_q = 0;
	logic [2:0] expq[$];
	logic [2:0] e;
	int n_fail = 0, num_checks = 0, n_bck, n_dck, n_launch, i;
	// pclk replaces convert clock, crystal
	always #12.5 pclk = ~pclk;
	pplt_far pplt_far_inst (.b_data_clock, .frame_sync_in, .d_clock);
	pplt_top #(.PWR_CYCLES(PWR)) pplt_top_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .role_select, .burst_length_select,
		.power_down_pin, .line_waveform_select,
		.signal_insert_enable(1'b0), .tone_insert(tone), .frame_sync_in,
		.b_data_clock, .b1_transmit_enable, .b2_transmit_enable(1'b0),
		.b_data_in, .b_data_out, .b_data_out_oe,
		.d_channel_clock_i(d_clock), .d_channel_clock_o,
		.d_channel_clock_oe, .d_channel_in_1, .d_channel_in_2,
		.d_channel_out_1, .d_channel_out_2, .b1_window_out, .b2_window_out,
		.b_channel_clock_out, .demod_ok, .demod_b1, .demod_b2, .demod_d1,
		.demod_d2, .mod_launch, .mod_b, .mod_d, .mod_power_on, .mod_square,
		.mod_burst_20);
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input string nm, input logic [32:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task complete_run;
		if (n_fail == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// apb transfer; pready and the answer are taken at the rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		logic ok;
		ok = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge pclk);
		penable <= 1;
		for (int k = 0; k < 20 && !ok; k++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
			begin
				ok = 1;
				rd = prdata;
				er = pslverr;
			end
		end
		{psel, penable} <= 2'b00;
		if (!ok)
		begin
			n_fail++;
			complete_run();
		end
	endtask
	// watch the slave B stream between edges, where outputs are settled
	always @(negedge pclk)
	begin
		bck_q <= b_channel_clock_out;
		dck_q <= d_channel_clock_o;
		if (mod_launch === 1'b1)
			n_launch++;
		if (b_channel_clock_out && !bck_q)
		begin
			n_bck++;
			if (!burst_length_select)
				check("dclk", d_channel_clock_o, b1_window_out);
			if (b_data_out_oe || b1_window_out || b2_window_out)
			begin
				e = (expq.size() > 0) ? expq.pop_front() : 3'bxxx;
				check("bout", {b_data_out_oe, b_data_out, b1_window_out,
					b2_window_out}, {1'b1, e});
			end
		end
		if (d_channel_clock_o && !dck_q)
		begin
			n_dck++;
			check("align", b_channel_clock_out && !bck_q, 1);
		end
	end
	// one demodulated master burst and the slave answer to it
	task slave_burst(input logic wide, input int lch, input logic tn);
		logic [7:0] b1, b2;
		{b2, b1} = 16'(rnd());
		@(posedge pclk);
		{demod_b1, demod_b2, demod_d1, demod_d2} <= {b1, b2, 4'(rnd())};
		{b_data_in, d_channel_in_1, d_channel_in_2} <= 3'(rnd());
		tone <= tn;
		// tone phase stays low until the first 40000-cycle tick
		if (tn)
			{b1, b2} = {TONE_LO, TONE_LO};
		for (int k = 7; k >= 0; k--)
			expq.push_back({b1[k], 2'b10});
		for (int k = 7; k >= 0 && wide; k--)
			expq.push_back({b2[k], 2'b01});
		{n_bck, n_dck, n_launch} = 0;
		// pins need two edges to pass the synchroniser
		repeat (4) @(posedge pclk);
		demod_ok <= 1;
		@(posedge pclk);
		demod_ok <= 0;
		repeat (10) @(posedge pclk);
		check("power", mod_power_on, 1);
		for (i = 0; i < 8000 && n_bck < 16; i++)
			@(posedge pclk);
		if (n_bck < 16)
		begin
			n_fail++;
			complete_run();
		end
		repeat (400) @(posedge pclk);
		check("periods", n_bck, 16);
		check("dclocks", n_dck, wide ? 2 : 1);
		check("left", expq.size(), 0);
		check("idle", {b_channel_clock_out, b_data_out_oe}, 0);
		check("launch", n_launch, lch);
		check("pong_b", mod_b[15:8], {8{b_data_in}});
		check("pong_d", {mod_d[2], mod_d[0]},
			{d_channel_in_1, d_channel_in_2});
	endtask
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		apb(0, ADDR_CTRL, 0);
		check("ctrl", rd, 32'h0000_0001);
		apb(1, ADDR_CTRL, 0);
		apb(0, 8'h0C, 0);
		check("unmapped", {er, rd}, 33'h1_0000_0000);
		slave_burst(1, 1, 0);
		burst_length_select <= 0;
		line_waveform_select <= 1;
		repeat (12) @(posedge pclk);
		check("shape", {mod_square, mod_burst_20}, 2'b10);
		slave_burst(0, 1, 1);
		apb(1, ADDR_CTRL, 1);
		repeat (PWR + 20) @(posedge pclk);
		check("sleep", mod_power_on, 0);
		slave_burst(0, 0, 0);
		apb(1, ADDR_CTRL, 0);
		power_down_pin <= 0;
		repeat (12) @(posedge pclk);
		check("pd", mod_power_on, 0);
		power_down_pin <= 1;
		role_select <= 1;
		burst_length_select <= 1;
		b1_transmit_enable <= 1;
		{demod_b1, demod_b2, demod_d1, demod_d2} <= 20'(rnd());
		repeat (12) @(posedge pclk);
		check("dck_oe", d_channel_clock_oe, 0);
		check("b20", mod_burst_20, 1);
		demod_ok <= 1;
		@(posedge pclk);
		demod_ok <= 0;
		n_launch = 0;
		pplt_far_inst.frame();
		check("d1", {d_channel_out_2, d_channel_out_1},
			{demod_d2[1], demod_d1[1]});
		check("ping", n_launch, 1);
		apb(0, ADDR_RXB, 0);
		check("rxb", rd, {12'h0, demod_d2, demod_d1, demod_b2,
			demod_b1});
		pplt_far_inst.d_beat();
		repeat (12) @(posedge pclk);
		check("d0", {d_channel_out_2, d_channel_out_1},
			{demod_d2[0], demod_d1[0]});
		// master B out follows the b1 enable, MSB first
		b1_transmit_enable <= 0;
		repeat (12) @(posedge pclk);
		check("b_oe", b_data_out_oe, 0);
		@(negedge b_data_clock);
		@(posedge pclk);
		b1_transmit_enable <= 1;
		for (i = 7; i >= 0; i--)
		begin
			@(negedge b_data_clock);
			check("b_mst", {b_data_out_oe, b_data_out},
				{1'b1, demod_b1[i]});
		end
		burst_length_select <= 0;
		b1_transmit_enable <= 0;
		repeat (12) @(posedge pclk);
		check("dck_z", d_channel_clock_oe, 0);
		check("b_oe_nb", b_data_out_oe, 0);
		apb(0, ADDR_STAT, 0);
		check("stat", rd[2:0], 3'b101);
		complete_run();
	end
endmodule
